// ===== src/odir_pkg.sv
/*
 * Shared constants for the output, digital port and interrupt register set.
 * Assumes a 32-bit local bus with byte offsets decoded on eight address bits.
 */
package odir_pkg;
    // ****************************************************************
    // Bus and register offsets.
    // ****************************************************************
    localparam int BUS_AW = 8;
    localparam int REG_W = 32;
    localparam logic [BUS_AW-1:0] OFS_IRQ_CTL = 8'h04;
    localparam logic [BUS_AW-1:0] OFS_OUT_SAMPLE = 8'h18;
    localparam logic [BUS_AW-1:0] OFS_OUT_FIFO_CTL = 8'h1c;
    localparam logic [BUS_AW-1:0] OFS_PPORT = 8'h24;
    localparam logic [BUS_AW-1:0] OFS_BOARD_CFG = 8'h28;
    // ****************************************************************
    // Field layouts.
    // ****************************************************************
    localparam int SMP_W = 20;
    localparam int FLUSH_BIT = 15;
    localparam int THR_W = 15;
    localparam int FAULT_N = 4;
    localparam int FCTL_W = 21;
    localparam int COUNT_W = 16;
    localparam int PORT_W = 16;
    localparam int BYTE_W = 8;
    localparam int PPORT_W = 20;
    localparam int GRP_N = 3;
    localparam int GRP_STRIDE = 4;
    localparam int SEL_W = 3;
    localparam int PEND_OFS = 3;
    localparam int COND_N = 8;
    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [THR_W-1:0] THR_RST = 15'h7ffe;
    localparam logic [REG_W-1:0] IRQ_CTL_RST = 32'h00000008;
    localparam logic [PORT_W-1:0] PORT_LAT_RST = 16'h0000;
    // ****************************************************************
    // Edge detector lanes and trigger codes.
    // ****************************************************************
    localparam int EDGE_AUX = 0;
    localparam int EDGE_IN_THR = 1;
    localparam int EDGE_OUT_THR = 2;
    localparam int EDGE_FAULT = 3;
    localparam int EDGE_N = 4;
    typedef enum logic [2:0] {G0_IDLE = 3'h0, G0_AUTOCAL = 3'h1, G0_AUX_RISE = 3'h2,
        G0_AUX_FALL = 3'h3, G0_LOOP_FAULT = 3'h4} odir_g0_sel_e;
    typedef enum logic [2:0] {G1_IDLE = 3'h0, G1_IN_RISE = 3'h1,
        G1_IN_FALL = 3'h2} odir_g1_sel_e;
    typedef enum logic [2:0] {G2_IDLE = 3'h0, G2_OUT_RISE = 3'h1, G2_OUT_FALL = 3'h2,
        G2_BURST = 3'h3} odir_g2_sel_e;
endpackage : odir_pkg

// ===== src/odir_grp_if.sv
/*
 * Carrier between the register decode and one interrupt request flag.
 * Assumes all users run on the single local clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface odir_grp_if;
    logic hit;
    logic wr;
    logic wr_val;
    logic pend;
    // The decode side drives events and writes, the flag side returns state.
    modport ctl (output hit, output wr, output wr_val, input pend);
    modport flag (input hit, input wr, input wr_val, output pend);
endinterface : odir_grp_if
`default_nettype wire

// ===== src/odir_edge_det.sv
/*
 * Rising and falling edge detector for a small vector of levels.
 * Assumes inputs synchronous to i_clk; no edge is seen in the first cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module odir_edge_det
    import odir_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [EDGE_N-1:0] i_sig,
    output logic [EDGE_N-1:0] o_rise,
    output logic [EDGE_N-1:0] o_fall
);
    logic [EDGE_N-1:0] prev_r;
    logic primed_r;

    // Hold last level; the primed flag stops a false edge after reset.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_r <= '0;
            primed_r <= 1'b0;
        end else begin
            prev_r <= i_sig;
            primed_r <= 1'b1;
        end
    end

    // One pulse per transition of each lane.
    genvar k;
    generate
        for (k = 0; k < EDGE_N; k++) begin : g_lane
            assign o_rise[k] = primed_r & i_sig[k] & ~prev_r[k];
            assign o_fall[k] = primed_r & ~i_sig[k] & prev_r[k];
        end
    endgenerate
endmodule : odir_edge_det
`default_nettype wire

// ===== src/odir_req_flag.sv
/*
 * One sticky interrupt request flag.
 * Assumes the decode side pulses hit once per qualifying event.
 */
`timescale 1ns/1ps
`default_nettype none
module odir_req_flag #(
    parameter logic RST_PEND = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    odir_grp_if.flag grp
);
    logic pend_r;
    logic pend_nxt;

    // An event in the cycle of a clearing write still sets the flag.
    assign pend_nxt = grp.hit | (grp.wr ? grp.wr_val : pend_r);

    // Flag storage.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend_r <= RST_PEND;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    assign grp.pend = pend_r;
endmodule : odir_req_flag
`default_nettype wire

// ===== src/odir_regs.sv
/*
 * Register set for output sample loading, output FIFO control, the 16-bit
 * digital port and three interrupt groups.
 * Assumes a local bus on i_clk with one-cycle read and write strobes, an
 * external FIFO that reports its occupancy and drains itself, and inputs
 * that are already synchronous to i_clk.
 */
// Summary of operation
// R1 - Sample port write pushes data 15:0 and channel tag 17:16.
// R2 - Bit 18 marks the last sample of a channel group.
// R3 - Bit 19 marks the last sample of a burst.
// R4 - Reading the sample port returns zero and leaves the FIFO alone.
// R5 - Written bits 31:20 of a sample are dropped.
// R6 - 15-bit threshold resets to 7ffe; bit 16 shows occupancy above it.
// R7 - Writing one to bit 15 empties the output FIFO.
// R8 - The flush bit clears itself once the FIFO is empty.
// R9 - Bits 17 to 20 show open-loop faults of outputs 0 to 3.
// R10 - Bits 18 and 19 make the low and high port bytes drive.
// R11 - After reset port bytes are inputs, latches zero, aux output zero.
// R12 - Group 0 codes: idle, calibration done, aux rise, aux fall, fault.
// R13 - Each aux transition fires its edge condition once.
// R14 - A request bit sets on its condition and clears on a zero write.
// R15 - Interrupt control resets to 0000_0008, group 0 idle and pending.
// R16 - Group 1 picks input threshold rise or fall; bit 7 is its request.
// R17 - Group 2 picks output threshold edges or burst done; bit 11 request.
// R18 - Conditions fire once per edge, not while they persist; calibration done and burst done fire in every cycle they are high.
// R19 - Interrupt output is high while a non-idle group has a request.
// R20 - Burst done fires when the burst-end sample is applied.
`timescale 1ns/1ps
`default_nettype none
module odir_regs
    import odir_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [BUS_AW-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [REG_W-1:0] i_wdata,
    output logic [REG_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_fifo_push,
    output logic [SMP_W-1:0] o_fifo_data,
    output logic o_fifo_flush,
    input wire logic [COUNT_W-1:0] i_fifo_count,
    input wire logic i_burst_applied,
    input wire logic i_in_thr_flag,
    input wire logic i_autocal_done,
    input wire logic [FAULT_N-1:0] i_loop_open_fault,
    input wire logic [PORT_W-1:0] i_dio,
    output logic [PORT_W-1:0] o_dio,
    output logic [PORT_W-1:0] o_dio_oe,
    input wire logic i_aux_in,
    output logic o_aux_out,
    input wire logic [REG_W-1:0] i_board_cfg,
    output logic o_irq
);

    // ****************************************************************
    // Address decode.
    // ****************************************************************

    // Exact match on all address bits: no aliases.
    // Compares the bus address with one register offset.
    function automatic logic addr_is(input logic [BUS_AW-1:0] addr,
                                     input logic [BUS_AW-1:0] ofs);
        addr_is = (addr == ofs);
    endfunction : addr_is

    logic sel_irq;
    logic sel_smp;
    logic sel_fctl;
    logic sel_port;
    logic sel_cfg;
    logic wr_irq;
    logic wr_smp;
    logic wr_fctl;
    logic wr_port;

    // One select per register; writes are selects qualified by the strobe.
    assign sel_irq = addr_is(i_addr, OFS_IRQ_CTL);
    assign sel_smp = addr_is(i_addr, OFS_OUT_SAMPLE);
    assign sel_fctl = addr_is(i_addr, OFS_OUT_FIFO_CTL);
    assign sel_port = addr_is(i_addr, OFS_PPORT);
    assign sel_cfg = addr_is(i_addr, OFS_BOARD_CFG);
    assign wr_irq = i_wr & sel_irq;
    assign wr_smp = i_wr & sel_smp;
    assign wr_fctl = i_wr & sel_fctl;
    assign wr_port = i_wr & sel_port;

    // ****************************************************************
    // Output sample port and FIFO control.
    // ****************************************************************

    logic push_r;
    logic push_nxt;
    logic [SMP_W-1:0] smp_r;
    logic [THR_W-1:0] thr_r;
    logic flush_r;
    logic flush_nxt;
    logic fifo_busy;
    logic out_thr_flag;

    // Samples offered while a flush is running are dropped with the rest.
    // Dropping pushes during a flush means the
    // FIFO is truly empty once it ends.
    assign push_nxt = wr_smp & ~flush_r; // R1
    assign fifo_busy = (i_fifo_count != '0);

    // Flush holds until the FIFO reports empty, then clears by itself.
    // The flush bit reads one for at least a cycle,
    // even when the FIFO was already empty.
    assign flush_nxt = (wr_fctl & i_wdata[FLUSH_BIT]) | (flush_r & fifo_busy); // R7 R8

    // Strictly greater than the threshold, zero-extended to the count width.
    // Live from the occupancy input, no delay.
    assign out_thr_flag = (i_fifo_count > COUNT_W'(thr_r)); // R6

    // Push strobe and flush state.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            push_r <= 1'b0;
            flush_r <= 1'b0;
        end else begin
            push_r <= push_nxt;
            flush_r <= flush_nxt;
        end
    end

    // Sample word with tag and end marks; the upper bits are never kept.
    // Data stands until the next accepted write.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            smp_r <= '0;
        end else if (push_nxt) begin
            smp_r <= i_wdata[SMP_W-1:0]; // R1 R2 R3 R5
        end
    end

    // Threshold field of the FIFO control register.
    // A flush write reloads the threshold too, so
    // software resends the value it wants.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            thr_r <= THR_RST; // R6
        end else if (wr_fctl) begin
            thr_r <= i_wdata[THR_W-1:0];
        end
    end

    // FIFO side outputs come straight from flops.
    assign o_fifo_push = push_r;
    assign o_fifo_data = smp_r;
    assign o_fifo_flush = flush_r;

    // ****************************************************************
    // Digital port.
    // ****************************************************************

    logic [PORT_W-1:0] lat_r;
    logic aux_out_r;
    logic lo_drv_r;
    logic hi_drv_r;
    logic [PORT_W-1:0] port_in;

    // Latches, aux output and byte directions; all inputs after reset.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lat_r <= PORT_LAT_RST; // R11
            aux_out_r <= 1'b0; // R11
            lo_drv_r <= 1'b0; // R11
            hi_drv_r <= 1'b0; // R11
        end else if (wr_port) begin
            lat_r <= i_wdata[PORT_W-1:0];
            aux_out_r <= i_wdata[PORT_W+1];
            lo_drv_r <= i_wdata[PORT_W+2];
            hi_drv_r <= i_wdata[PORT_W+3];
        end
    end

    // A byte drives its pins only while its direction bit is high.
    // Directions gate whole bytes, not single bits.
    assign o_dio = lat_r;
    assign o_dio_oe = {{BYTE_W{hi_drv_r}}, {BYTE_W{lo_drv_r}}}; // R10
    assign o_aux_out = aux_out_r;

    // Reads show the latch for driven bytes and the pins for input bytes.
    // Undriven bytes follow the pins every cycle.
    assign port_in = (o_dio_oe & lat_r) | (~o_dio_oe & i_dio);

    // ****************************************************************
    // Interrupt conditions.
    // ****************************************************************

    logic [EDGE_N-1:0] edge_sig;
    logic [EDGE_N-1:0] edge_rise;
    logic [EDGE_N-1:0] edge_fall;
    logic any_fault;

    // Levels watched for transitions.
    // A second fault while one is open raises no
    // new edge on the combined lane.
    assign any_fault = |i_loop_open_fault;
    assign edge_sig[EDGE_AUX] = i_aux_in;
    assign edge_sig[EDGE_IN_THR] = i_in_thr_flag;
    assign edge_sig[EDGE_OUT_THR] = out_thr_flag;
    assign edge_sig[EDGE_FAULT] = any_fault;

    // Turns each level into one pulse per rising and falling transition.
    odir_edge_det u_edge (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_sig(edge_sig), // R13 R18
        .o_rise(edge_rise),
        .o_fall(edge_fall)
    );

    logic [COND_N-1:0] cond0;
    logic [COND_N-1:0] cond1;
    logic [COND_N-1:0] cond2;

    // Per-code event vectors; reserved and idle codes never fire.
    // Pulse inputs are used without edge detection.
    always_comb begin
        cond0 = '0;
        cond1 = '0;
        cond2 = '0;
        cond0[G0_AUTOCAL] = i_autocal_done; // R12
        cond0[G0_AUX_RISE] = edge_rise[EDGE_AUX]; // R12 R13
        cond0[G0_AUX_FALL] = edge_fall[EDGE_AUX]; // R12 R13
        cond0[G0_LOOP_FAULT] = edge_rise[EDGE_FAULT]; // R12 R18
        cond1[G1_IN_RISE] = edge_rise[EDGE_IN_THR]; // R16
        cond1[G1_IN_FALL] = edge_fall[EDGE_IN_THR]; // R16
        cond2[G2_OUT_RISE] = edge_rise[EDGE_OUT_THR]; // R17
        cond2[G2_OUT_FALL] = edge_fall[EDGE_OUT_THR]; // R17
        cond2[G2_BURST] = i_burst_applied; // R20
    end

    // ****************************************************************
    // Interrupt groups.
    // ****************************************************************

    logic [SEL_W-1:0] trig_sel_r [GRP_N];
    logic [COND_N-1:0] cond_v [GRP_N];
    logic [GRP_N-1:0] grp_active;
    logic [REG_W-1:0] irq_word;
    logic irq_r;

    // Condition vectors indexed by group number.
    assign cond_v[0] = cond0;
    assign cond_v[1] = cond1;
    assign cond_v[2] = cond2;
    assign irq_word[REG_W-1:GRP_N*GRP_STRIDE] = '0;

    odir_grp_if grp_if [GRP_N] ();

    genvar g;
    generate
        for (g = 0; g < GRP_N; g++) begin : g_grp
            // Trigger select field of this group.
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    trig_sel_r[g] <= IRQ_CTL_RST[g*GRP_STRIDE +: SEL_W]; // R15
                end else if (wr_irq) begin
                    trig_sel_r[g] <= i_wdata[g*GRP_STRIDE +: SEL_W];
                end
            end

            // Event selected by the current code, plus the bus write.
            // Reserved codes pick an empty condition slot,
            // so they are stored but never set a request.
            assign grp_if[g].hit = cond_v[g][trig_sel_r[g]]; // R12 R16 R17
            assign grp_if[g].wr = wr_irq; // R14
            assign grp_if[g].wr_val = i_wdata[g*GRP_STRIDE+PEND_OFS]; // R14

            // Sticky request flag with its reset level.
            odir_req_flag #(
                .RST_PEND(IRQ_CTL_RST[g*GRP_STRIDE+PEND_OFS]) // R15
            ) u_flag (
                .i_clk(i_clk),
                .i_rst_b(i_rst_b),
                .grp(grp_if[g])
            );

            // A group asks for service only while not idle.
            assign grp_active[g] = grp_if[g].pend & (trig_sel_r[g] != '0); // R19
            assign irq_word[g*GRP_STRIDE +: GRP_STRIDE] = {grp_if[g].pend, trig_sel_r[g]};
        end
    endgenerate

    // Registered request toward the bridge.
    // One cycle of latency buys a glitch-free line.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |grp_active; // R19
        end
    end

    assign o_irq = irq_r;

    // ****************************************************************
    // Read path.
    // ****************************************************************

    logic [FCTL_W-1:0] fctl_bits;
    logic [PPORT_W-1:0] port_bits;
    logic [REG_W-1:0] rd_mux;
    logic [REG_W-1:0] rdata_r;
    logic rvalid_r;

    // Status views of the FIFO control and the digital port.
    assign fctl_bits = {i_loop_open_fault, out_thr_flag, flush_r, thr_r}; // R6 R9
    assign port_bits = {hi_drv_r, lo_drv_r, aux_out_r, i_aux_in, port_in};

    // The sample port and unmapped offsets read as zero.
    assign rd_mux = sel_irq ? irq_word :
                    sel_fctl ? REG_W'(fctl_bits) :
                    sel_port ? REG_W'(port_bits) :
                    sel_cfg ? i_board_cfg :
                    '0; // R4

    // Read data is captured on the strobe and held until the next read.
    // A read in the cycle of a write returns the
    // value from before that write.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_rd;
            if (i_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Bus outputs come straight from flops.
    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;

endmodule : odir_regs
`default_nettype wire

// ===== dv/odir_regs_props.sv
/*
 * Port-level checker for the output, digital port and interrupt register set.
 * Assumes one clock, an active-low async reset and a bind onto odir_regs.
 */
`timescale 1ns/1ps
`default_nettype none
module odir_regs_props
    import odir_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [BUS_AW-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [REG_W-1:0] i_wdata,
    input wire logic [REG_W-1:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_fifo_push,
    input wire logic [SMP_W-1:0] o_fifo_data,
    input wire logic o_fifo_flush,
    input wire logic [COUNT_W-1:0] i_fifo_count,
    input wire logic [FAULT_N-1:0] i_loop_open_fault,
    input wire logic [PORT_W-1:0] o_dio,
    input wire logic [PORT_W-1:0] o_dio_oe,
    input wire logic o_aux_out
);
    // ********
    // Decoded requests.
    // ********
    wire logic smp_wr = i_wr && i_addr == OFS_OUT_SAMPLE;
    wire logic fctl_rd = i_rd && i_addr == OFS_OUT_FIFO_CTL;
    wire logic fl_wr = i_wr && i_addr == OFS_OUT_FIFO_CTL && i_wdata[FLUSH_BIT];
    wire logic pp_wr = i_wr && i_addr == OFS_PPORT;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ********
    // Properties.
    // ********
    property p_push_data;
        smp_wr && !o_fifo_flush |=> o_fifo_push && o_fifo_data == $past(i_wdata[SMP_W-1:0]);
    endproperty
    a_push_data: assert property (p_push_data) else $error("sample push wrong");
    property p_push_cause;
        o_fifo_push |-> $past(i_wr) && $past(i_addr) == OFS_OUT_SAMPLE;
    endproperty
    a_push_cause: assert property (p_push_cause) else $error("push without write");
    property p_sample_rd;
        i_rd && i_addr == OFS_OUT_SAMPLE |=> o_rvalid && o_rdata == 32'h0;
    endproperty
    a_sample_rd: assert property (p_sample_rd) else $error("sample port read not zero");
    property p_thr;
        fctl_rd |=> o_rdata[16] == ($past(i_fifo_count) > {1'b0, o_rdata[14:0]});
    endproperty
    a_thr: assert property (p_thr) else $error("threshold flag wrong");
    property p_flush_start;
        fl_wr |=> o_fifo_flush;
    endproperty
    a_flush_start: assert property (p_flush_start) else $error("flush did not start");
    property p_flush_end;
        o_fifo_flush && i_fifo_count == 16'h0 && !fl_wr |=> !o_fifo_flush;
    endproperty
    a_flush_end: assert property (p_flush_end) else $error("flush did not end");
    property p_fault;
        fctl_rd |=> o_rdata[20:17] == $past(i_loop_open_fault);
    endproperty
    a_fault: assert property (p_fault) else $error("fault bits wrong");
    property p_oe;
        pp_wr |=> o_dio_oe == {{8{$past(i_wdata[19])}}, {8{$past(i_wdata[18])}}};
    endproperty
    a_oe: assert property (p_oe) else $error("drive enable wrong");
    property p_latch;
        pp_wr |=> o_dio == $past(i_wdata[15:0]) && o_aux_out == $past(i_wdata[17]);
    endproperty
    a_latch: assert property (p_latch) else $error("port latch wrong");
    // Main scenarios seen.
    c_push: cover property (o_fifo_push);
    c_flush: cover property ($rose(o_fifo_flush));
    c_port: cover property (pp_wr);
endmodule : odir_regs_props
bind odir_regs odir_regs_props chk_u (.i_clk, .i_rst_b, .i_addr, .i_wr, .i_rd, .i_wdata,
    .o_rdata, .o_rvalid, .o_fifo_push, .o_fifo_data, .o_fifo_flush, .i_fifo_count,
    .i_loop_open_fault, .o_dio, .o_dio_oe, .o_aux_out);
`default_nettype wire

// ===== dv/odir_fifo_model.sv
/*
 * Output FIFO and drain model standing behind the sample port.
 * Assumes pushes and flush from odir_regs; drains one word in four cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module odir_fifo_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_push,
    input wire logic [19:0] i_data,
    input wire logic i_flush,
    input wire logic i_run,
    output logic [15:0] o_count,
    output logic o_burst_applied
);
    logic [19:0] q[$];
    logic [1:0] pace_r;
    // Queue, drain pacing and the burst-applied pulse.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q.delete();
            o_count <= 16'h0;
            pace_r <= 2'h0;
            o_burst_applied <= 1'b0;
        end else begin
            o_burst_applied <= 1'b0;
            pace_r <= pace_r + 2'h1;
            if (i_flush) begin
                q.delete();
            end else begin
                if (i_run && pace_r == 2'h3 && q.size() > 0) begin
                    o_burst_applied <= q[0][19];
                    void'(q.pop_front());
                end
                if (i_push) begin
                    q.push_back(i_data);
                end
            end
            // Updated non-blocking so the design reads it race-free.
            o_count <= 16'(q.size());
        end
    end
endmodule : odir_fifo_model
`default_nettype wire

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the register set with a FIFO model.
 * Assumes a 100 MHz clock and inputs driven 1 ns after the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import odir_pkg::*;
    logic clk, rst_b, bus_wr, bus_rd, aux, cal, in_thr, run;
    logic rvalid, push, flush, burst, aux_o, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, cfg;
    logic [19:0] fdata;
    logic [15:0] dio, dio_o, oe, cnt;
    logic [3:0] fault;
    int errors, tests_run;
    localparam logic [11:0] SEL [13] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h002,
        12'h005, 12'h010, 12'h020, 12'h030, 12'h100, 12'h200, 12'h300, 12'h400};
    localparam int KND [13] = '{2, 0, 1, 3, 1, 0, 4, 5, 4, 6, 7, 8, 8};
    localparam logic [11:0] MSK [13] = '{12'h008, 12'h008, 12'h008, 12'h008, 12'h000,
        12'h000, 12'h080, 12'h080, 12'h000, 12'h800, 12'h800, 12'h800, 12'h000};
    odir_regs dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr(bus_wr),
        .i_rd(bus_rd), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_fifo_push(push), .o_fifo_data(fdata), .o_fifo_flush(flush),
        .i_fifo_count(cnt), .i_burst_applied(burst), .i_in_thr_flag(in_thr),
        .i_autocal_done(cal), .i_loop_open_fault(fault), .i_dio(dio), .o_dio(dio_o),
        .o_dio_oe(oe), .i_aux_in(aux), .o_aux_out(aux_o), .i_board_cfg(cfg), .o_irq(irq));
    odir_fifo_model fifo_u (.i_clk(clk), .i_rst_b(rst_b), .i_push(push), .i_data(fdata),
        .i_flush(flush), .i_run(run), .o_count(cnt), .o_burst_applied(burst));
    // ********
    // Bus tasks and checks.
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 bus_wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 bus_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1 bus_rd = 1'b1;
        addr = a;
        @(posedge clk);
        #1 bus_rd = 1'b0;
    endtask : rd
    task automatic end_of_test;
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Sets the levels that precede a trigger, so no edge is seen yet.
    task automatic pre(input int k);
        fault = 4'h0;
        run = (k == 8);
        aux = (k == 1);
        in_thr = (k == 5);
        if (k == 6 || k == 8) wr(OFS_OUT_FIFO_CTL, 32'h8000);
        if (k == 7) wr(OFS_OUT_SAMPLE, 32'h0);
    endtask : pre
    // Makes one trigger event of the given kind.
    task automatic fire(input int k);
        @(posedge clk);
        #1;
        case (k)
            0: aux = 1'b1;
            1: aux = 1'b0;
            2: cal = 1'b1;
            3: fault = 4'h2;
            4: in_thr = 1'b1;
            5: in_thr = 1'b0;
            6: wr(OFS_OUT_SAMPLE, 32'h0);
            7: wr(OFS_OUT_FIFO_CTL, 32'h8000);
            default: wr(OFS_OUT_SAMPLE, 32'h0008_0000);
        endcase
        @(posedge clk);
        #1 cal = 1'b0;
    endtask : fire
    // ********
    // Clock, watchdog and main sequence.
    // ********
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200us;
        errors++;
        end_of_test();
    end
    initial begin
        {rst_b, bus_wr, bus_rd, aux, cal, in_thr, run} = 7'h0;
        addr = 8'h00;
        wdata = 32'h0;
        cfg = 32'h0012_3456;
        dio = 16'hc33c;
        fault = 4'h0;
        errors = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        chk(irq, 32'h0);
        rd(OFS_IRQ_CTL);
        chk(rdata, 32'h8);
        rd(OFS_OUT_FIFO_CTL);
        chk(rdata, 32'h7ffe);
        rd(OFS_PPORT);
        chk(rdata, 32'hc33c);
        chk({dio_o, oe}, 32'h0);
        rd(8'h30);
        chk(rdata, 32'h0);
        wr(OFS_BOARD_CFG, 32'hffff_ffff);
        rd(OFS_BOARD_CFG);
        chk(rdata, cfg);
        wr(OFS_OUT_FIFO_CTL, 32'h2);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_OUT_SAMPLE, {12'hfff, c == 3, c[0], c[1:0], 16'h1000 + 16'(c)});
        end
        chk(fdata, 20'hf1003);
        rd(OFS_OUT_SAMPLE);
        chk(rdata, 32'h0);
        chk(cnt, 32'h4);
        rd(OFS_OUT_FIFO_CTL);
        chk(rdata, 32'h0001_0002);
        fault = 4'ha;
        wr(OFS_OUT_FIFO_CTL, 32'h4);
        rd(OFS_OUT_FIFO_CTL);
        chk(rdata, 32'h0014_0004);
        wr(OFS_OUT_FIFO_CTL, 32'h8000);
        repeat (3) @(posedge clk);
        rd(OFS_OUT_FIFO_CTL);
        chk(rdata, 32'h0014_0000);
        chk(cnt, 32'h0);
        wr(OFS_PPORT, 32'h0006_5aa5);
        chk({oe, 15'h0, aux_o}, 32'h00ff_0001);
        rd(OFS_PPORT);
        chk(rdata, 32'h0006_c3a5);
        wr(OFS_PPORT, 32'h0008_0000);
        rd(OFS_PPORT);
        chk({oe, rdata[15:0]}, 32'hff00_003c);
        for (int i = 0; i < 13; i++) begin
            pre(KND[i]);
            repeat (4) @(posedge clk);
            wr(OFS_IRQ_CTL, {20'h0, SEL[i]});
            fire(KND[i]);
            repeat (10) @(posedge clk);
            rd(OFS_IRQ_CTL);
            chk(rdata, {20'h0, SEL[i] | MSK[i]});
            chk(irq, 32'(MSK[i] != 12'h0));
            wr(OFS_IRQ_CTL, {20'h0, SEL[i]});
            repeat (6) @(posedge clk);
            rd(OFS_IRQ_CTL);
            chk(rdata, {20'h0, SEL[i]});
        end
        wr(OFS_IRQ_CTL, 32'h8);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
